//--- hw/sctc_pkg.sv
// Package for the sensor channel tracking configuration register bank
package sctc_pkg;
    // ******************************************************************
    // Register byte offsets
    // ******************************************************************
    localparam logic [7:0] SCTC_OFF_SENSOR2_SETUP = 8'h24; // Channel 2 sensor setup
    localparam logic [7:0] SCTC_OFF_CHAN0_TRACK = 8'h25; // Channel 0 tracking factor
    localparam logic [7:0] SCTC_OFF_SENSOR3_SETUP = 8'h26; // Channel 3 sensor setup
    localparam logic [7:0] SCTC_OFF_CHAN12_TRACK = 8'h28; // Channels 1 and 2 tracking factors
    localparam logic [7:0] SCTC_OFF_CHAN3_TRACK = 8'h2b; // Channel 3 tracking factor

    // ******************************************************************
    // Values after reset
    // ******************************************************************
    localparam logic [7:0] SCTC_RST_SENSOR_SETUP = 8'h04; // Low range, lowest band, 4 cycles
    localparam logic [7:0] SCTC_RST_CHAN0_TRACK = 8'hda; // Reserved 1bh above factor 1
    localparam logic [7:0] SCTC_RST_CHAN12_TRACK = 8'h50; // Both factors 1
    localparam logic [7:0] SCTC_RST_CHAN3_TRACK = 8'h01; // Factor 1

    // ******************************************************************
    // Field positions
    // ******************************************************************
    localparam int SCTC_RANGE_BIT = 7; // Resistance range select
    localparam int SCTC_BAND_HI = 6; // Frequency band, top bit
    localparam int SCTC_BAND_LO = 5; // Frequency band, bottom bit
    localparam int SCTC_CYC_HI = 4; // Cycle count, top bit
    localparam int SCTC_CYC_LO = 0; // Cycle count, bottom bit
    localparam int SCTC_TF0_LO = 1; // Channel 0 factor, bits 2-1
    localparam int SCTC_TF1_LO = 4; // Channel 1 factor, bits 5-4
    localparam int SCTC_TF2_LO = 6; // Channel 2 factor, bits 7-6
    localparam int SCTC_TF3_LO = 0; // Channel 3 factor, bits 1-0

    // ******************************************************************
    // Frequency band codes
    // ******************************************************************
    localparam logic [1:0] SCTC_BAND_LOW = 2'h0; // 1 to 3.3 MHz
    localparam logic [1:0] SCTC_BAND_MID = 2'h1; // 3.3 to 10 MHz
    localparam logic [1:0] SCTC_BAND_HIGH = 2'h2; // 10 to 30 MHz
    localparam logic [1:0] SCTC_BAND_RSVD = 2'h3; // No defined band

    // Storage slots, one per mapped register
    localparam int SCTC_NUM_REGS = 5;
    typedef enum logic [2:0] {
        SCTC_IDX_S2,
        SCTC_IDX_T0,
        SCTC_IDX_S3,
        SCTC_IDX_T12,
        SCTC_IDX_T3,
        SCTC_IDX_NONE
    } sctc_idx_t;
endpackage

//--- hw/sctc_regs.sv
// Configuration register bank for sensor channel setup and fast tracking factors
`timescale 1ns/1ps
module sctc_regs (
    input wire logic clk_sys, // 250 MHz system clock
    input wire logic reset, // Synchronous, active high
    input wire logic [7:0] reg_addr, // Register byte address from the serial engine
    input wire logic reg_wr, // Write strobe, one cycle
    input wire logic [7:0] reg_wdata, // Write data
    output logic [7:0] reg_rdata, // Read data, one cycle after the address
    output logic chan2_resistance_range, // 0 selects 50 ohm to 4 kohm
    output logic chan3_resistance_range, // 1 selects 800 ohm to 10 kohm
    output logic [1:0] chan2_band_select, // Oscillation band code
    output logic [1:0] chan3_band_select, // Oscillation band code
    output logic [4:0] chan2_cycle_count, // Sensor cycles per sample window
    output logic [4:0] chan3_cycle_count, // Sensor cycles per sample window
    output logic chan2_band_reserved, // Band code 3 present, setup invalid
    output logic chan3_band_reserved, // Band code 3 present, setup invalid
    output logic [1:0] chan0_track_factor, // Baseline fast tracking speed
    output logic [1:0] chan1_track_factor, // Baseline fast tracking speed
    output logic [1:0] chan2_track_factor, // Baseline fast tracking speed
    output logic [1:0] chan3_track_factor // Baseline fast tracking speed
);
    import sctc_pkg::*;

    // ******************************************************************
    // Address decode
    // ******************************************************************

    // Maps a byte address to a storage slot; used by both write and read
    function automatic sctc_idx_t addr_to_idx(input logic [7:0] addr);
        case (addr)
            SCTC_OFF_SENSOR2_SETUP: addr_to_idx = SCTC_IDX_S2;
            SCTC_OFF_CHAN0_TRACK: addr_to_idx = SCTC_IDX_T0;
            SCTC_OFF_SENSOR3_SETUP: addr_to_idx = SCTC_IDX_S3;
            SCTC_OFF_CHAN12_TRACK: addr_to_idx = SCTC_IDX_T12;
            SCTC_OFF_CHAN3_TRACK: addr_to_idx = SCTC_IDX_T3;
            default: addr_to_idx = SCTC_IDX_NONE;
        endcase
    endfunction

    sctc_idx_t addr_idx; // Slot hit by the current address
    logic [7:0] regs [SCTC_NUM_REGS]; // Register storage, flip-flops

    // Decoded once here so the write and read paths always agree on the slot
    assign addr_idx = addr_to_idx(reg_addr);

    // ******************************************************************
    // Register storage
    // ******************************************************************

    // Every bit is writable, reserved ones included, so the host must
    // read-modify-write to keep reserved bits at their reset values
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            regs[SCTC_IDX_S2] <= SCTC_RST_SENSOR_SETUP;
            regs[SCTC_IDX_T0] <= SCTC_RST_CHAN0_TRACK;
            regs[SCTC_IDX_S3] <= SCTC_RST_SENSOR_SETUP;
            regs[SCTC_IDX_T12] <= SCTC_RST_CHAN12_TRACK;
            regs[SCTC_IDX_T3] <= SCTC_RST_CHAN3_TRACK;
        end else if (reg_wr && addr_idx != SCTC_IDX_NONE) begin
            // Unmapped writes are dropped silently
            regs[addr_idx] <= reg_wdata;
        end
    end

    // Read path registered; unmapped addresses read zero
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (addr_idx == SCTC_IDX_NONE) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= regs[addr_idx];
        end
    end

    // ******************************************************************
    // Field outputs to the front end
    // ******************************************************************

    // Sensor setup fields straight from storage flip-flops
    assign chan2_resistance_range = regs[SCTC_IDX_S2][SCTC_RANGE_BIT];
    assign chan3_resistance_range = regs[SCTC_IDX_S3][SCTC_RANGE_BIT];
    assign chan2_band_select = regs[SCTC_IDX_S2][SCTC_BAND_HI:SCTC_BAND_LO];
    assign chan3_band_select = regs[SCTC_IDX_S3][SCTC_BAND_HI:SCTC_BAND_LO];
    assign chan2_cycle_count = regs[SCTC_IDX_S2][SCTC_CYC_HI:SCTC_CYC_LO];
    assign chan3_cycle_count = regs[SCTC_IDX_S3][SCTC_CYC_HI:SCTC_CYC_LO];

    // Reserved band flagged so the front end can hold off rather than guess
    assign chan2_band_reserved = (chan2_band_select == SCTC_BAND_RSVD);
    assign chan3_band_reserved = (chan3_band_select == SCTC_BAND_RSVD);

    // Tracking factors at their documented bit positions
    assign chan0_track_factor = regs[SCTC_IDX_T0][SCTC_TF0_LO +: 2];
    assign chan1_track_factor = regs[SCTC_IDX_T12][SCTC_TF1_LO +: 2];
    assign chan2_track_factor = regs[SCTC_IDX_T12][SCTC_TF2_LO +: 2];
    assign chan3_track_factor = regs[SCTC_IDX_T3][SCTC_TF3_LO +: 2];

    // ******************************************************************
    // Assertions
    // ******************************************************************

    a_reset_defaults: assert property (@(posedge clk_sys) disable iff (reset)
        $fell(reset) |-> (chan0_track_factor == 2'h1 && chan1_track_factor == 2'h1 &&
            chan2_track_factor == 2'h1 && chan3_track_factor == 2'h1 &&
            regs[SCTC_IDX_T0] == 8'hda))
        else $error("Tracking registers wrong after reset");

    a_setup_defaults: assert property (@(posedge clk_sys) disable iff (reset)
        $fell(reset) |-> (chan2_cycle_count == 5'h04 && chan3_cycle_count == 5'h04 &&
            !chan2_resistance_range && chan3_band_select == SCTC_BAND_LOW))
        else $error("Sensor setup wrong after reset");

    a_range_write: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_wr && reg_addr == 8'h26) |=> chan3_resistance_range == $past(reg_wdata[7]))
        else $error("Channel 3 range not taken from bit 7");

    a_band_write: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_wr && reg_addr == 8'h24) |=> chan2_band_select == $past(reg_wdata[6:5]))
        else $error("Channel 2 band not taken from bits 6-5");

    a_cycle_write: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_wr && reg_addr == 8'h24) |=> chan2_cycle_count == $past(reg_wdata[4:0]))
        else $error("Channel 2 cycle count not taken from bits 4-0");

    a_shared_track: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_wr && reg_addr == 8'h28) |=>
            (chan2_track_factor == $past(reg_wdata[7:6]) && chan1_track_factor == $past(reg_wdata[5:4])))
        else $error("Shared tracking register fields misplaced");

    a_track_hold: assert property (@(posedge clk_sys) disable iff (reset)
        (!reg_wr ##1 !reg_wr) |=> $stable(chan0_track_factor) && $stable(chan3_track_factor))
        else $error("Tracking factor changed without a write");

    a_read_back: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_addr == 8'h25 && !reg_wr) |=> reg_rdata[2:1] == chan0_track_factor)
        else $error("Channel 0 factor read back wrong");

    // The hole between the channel 3 setup and the shared factor byte reads zero
    a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_addr == 8'h27) |=> reg_rdata == 8'h00)
        else $error("Unmapped read not zero");

    // ******************************************************************
    // Assertions on the reset load
    // ******************************************************************

    // Reset must win over a write presented in the same cycle, so every
    // factor shows its reset value one edge after any reset edge
    a_reset_load: assert property (@(posedge clk_sys)
        reset |=> (chan0_track_factor == SCTC_RST_CHAN0_TRACK[SCTC_TF0_LO +: 2] &&
            chan1_track_factor == SCTC_RST_CHAN12_TRACK[SCTC_TF1_LO +: 2] &&
            chan2_track_factor == SCTC_RST_CHAN12_TRACK[SCTC_TF2_LO +: 2] &&
            chan3_track_factor == SCTC_RST_CHAN3_TRACK[SCTC_TF3_LO +: 2]))
        else $error("Tracking factors not reloaded by reset");

    // Setup fields of both sensors reload too: low range, lowest band, 4 cycles
    a_reset_setup: assert property (@(posedge clk_sys)
        reset |=> (chan2_resistance_range == SCTC_RST_SENSOR_SETUP[SCTC_RANGE_BIT] &&
            chan3_resistance_range == SCTC_RST_SENSOR_SETUP[SCTC_RANGE_BIT] &&
            chan2_band_select == SCTC_BAND_LOW && chan3_band_select == SCTC_BAND_LOW &&
            chan2_cycle_count == SCTC_RST_SENSOR_SETUP[SCTC_CYC_HI:SCTC_CYC_LO] &&
            chan3_cycle_count == SCTC_RST_SENSOR_SETUP[SCTC_CYC_HI:SCTC_CYC_LO]))
        else $error("Sensor setup not reloaded by reset");

    // The read port starts from zero so the host never sees a stale byte
    a_reset_rdata: assert property (@(posedge clk_sys)
        reset |=> reg_rdata == 8'h00)
        else $error("Read data not cleared by reset");

    // ******************************************************************
    // Assertions on the write path
    // ******************************************************************

    // Channel 2 range comes from bit 7 of its own setup byte
    a_range2_write: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_wr && reg_addr == SCTC_OFF_SENSOR2_SETUP) |=>
            chan2_resistance_range == $past(reg_wdata[7]))
        else $error("Channel 2 range not taken from bit 7");

    // Channel 3 band and cycle count come from bits 6-5 and 4-0 of its byte
    a_setup3_write: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_wr && reg_addr == SCTC_OFF_SENSOR3_SETUP) |=>
            (chan3_band_select == $past(reg_wdata[6:5]) && chan3_cycle_count == $past(reg_wdata[4:0])))
        else $error("Channel 3 band or cycle count misplaced");

    // Channel 0 factor sits in bits 2-1, between reserved bits
    a_track0_write: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_wr && reg_addr == SCTC_OFF_CHAN0_TRACK) |=>
            chan0_track_factor == $past(reg_wdata[2:1]))
        else $error("Channel 0 factor not taken from bits 2-1");

    // Channel 3 factor sits in the two lowest bits, all four codes legal
    a_track3_write: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_wr && reg_addr == SCTC_OFF_CHAN3_TRACK) |=>
            chan3_track_factor == $past(reg_wdata[1:0]))
        else $error("Channel 3 factor not taken from bits 1-0");

    // A write elsewhere must leave the channel 2 setup untouched
    a_setup_isolation: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_wr && reg_addr != SCTC_OFF_SENSOR2_SETUP) |=>
            ($stable(chan2_cycle_count) && $stable(chan2_band_select) &&
            $stable(chan2_resistance_range)))
        else $error("Channel 2 setup changed by another write");

    // ******************************************************************
    // Assertions on the read path
    // ******************************************************************

    // Channel 3 setup reads back one edge after its address, fields in place
    a_setup3_read: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_addr == SCTC_OFF_SENSOR3_SETUP && !reg_wr) |=>
            reg_rdata == {chan3_resistance_range, chan3_band_select, chan3_cycle_count})
        else $error("Channel 3 setup read back wrong");
endmodule // sctc_regs

//--- test/sctc_host.sv
// Host model that reaches the configuration bank through its byte port
`timescale 1ns/1ps
module sctc_host (
    input wire logic clk_sys,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
    end
    // One-byte write; band code 3 is never sent by this host
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wr <= 1'b1;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_wdata <= ~d; // Stale data is shown inverted, never held
    endtask
    // Read answers one edge after the address is taken
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk_sys);
        reg_addr <= a;
        @(posedge clk_sys);
        #1 q = reg_rdata;
    endtask
    // Write, then read the same address in that edge and the next
    task automatic wr_peek(input logic [7:0] a, input logic [7:0] d, output logic [7:0] old_q, output logic [7:0] new_q);
        wr(a, d);
        #1 old_q = reg_rdata;
        @(posedge clk_sys);
        #1 new_q = reg_rdata;
    endtask
    // Reserved bits keep their value only because the host merges
    task automatic rmw(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
        logic [7:0] t;
        rd(a, t);
        wr(a, (t & ~m) | (v & m));
    endtask
endmodule // sctc_host

//--- test/sensor_channel_tracking_config_bench.sv
// Self-checking bench for the channel configuration register bank
`timescale 1ns/1ps
module sensor_channel_tracking_config_bench;
    import sctc_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] q;} sctc_row_t;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, q, q2;
    logic reg_wr, chan2_resistance_range, chan3_resistance_range, chan2_band_reserved, chan3_band_reserved;
    logic [1:0] chan2_band_select, chan3_band_select, chan0_track_factor, chan1_track_factor;
    logic [1:0] chan2_track_factor, chan3_track_factor;
    logic [4:0] chan2_cycle_count, chan3_cycle_count;
    logic [7:0] sh [6]; // Expected register contents, slot order of the package
    logic [7:0] offs [5] = '{SCTC_OFF_SENSOR2_SETUP, SCTC_OFF_CHAN0_TRACK, SCTC_OFF_SENSOR3_SETUP,
        SCTC_OFF_CHAN12_TRACK, SCTC_OFF_CHAN3_TRACK};
    int err_count = 0;
    int tests_run = 0;
    // Address, data written, byte read back; last row is unmapped
    sctc_row_t rows [8] = '{'{8'h24, 8'h9f, 8'h9f}, '{8'h26, 8'h40, 8'h40}, '{8'h24, 8'h20, 8'h20},
        '{8'h25, 8'h5c, 8'h5c}, '{8'h28, 8'ha0, 8'ha0}, '{8'h2b, 8'h03, 8'h03}, '{8'h28, 8'h00, 8'h00},
        '{8'h27, 8'h55, 8'h00}};
    wire logic [25:0] got = {chan2_resistance_range, chan3_resistance_range, chan2_band_select, chan3_band_select,
        chan2_cycle_count, chan3_cycle_count, chan0_track_factor, chan1_track_factor, chan2_track_factor,
        chan3_track_factor, chan2_band_reserved, chan3_band_reserved};
    always #2 clk_sys = ~clk_sys;
    sctc_regs dut (.clk_sys, .reset, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .chan2_resistance_range,
        .chan3_resistance_range, .chan2_band_select, .chan3_band_select, .chan2_cycle_count, .chan3_cycle_count,
        .chan2_band_reserved, .chan3_band_reserved, .chan0_track_factor, .chan1_track_factor, .chan2_track_factor,
        .chan3_track_factor);
    sctc_host host (.clk_sys, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr);
    // Field outputs worked out from the expected register bytes
    function automatic logic [25:0] fexp();
        return {sh[0][7], sh[2][7], sh[0][6:5], sh[2][6:5], sh[0][4:0], sh[2][4:0], sh[1][2:1], sh[3][5:4],
            sh[3][7:6], sh[4][1:0], sh[0][6:5] == 2'h3, sh[2][6:5] == 2'h3};
    endfunction
    function automatic int slot(input logic [7:0] a);
        for (int i = 0; i < 5; i++) if (offs[i] == a) return i;
        return 5;
    endfunction
    task automatic rst_sh();
        sh = '{SCTC_RST_SENSOR_SETUP, SCTC_RST_CHAN0_TRACK, SCTC_RST_SENSOR_SETUP, SCTC_RST_CHAN12_TRACK,
            SCTC_RST_CHAN3_TRACK, 8'h00};
    endtask
    task automatic chk(input string n, input logic [25:0] e, input logic [25:0] s);
        tests_run++;
        if (s !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            err_count++;
        end
    endtask
    // Every mapped byte and all field outputs against the expected copy
    task automatic chk_all();
        for (int i = 0; i < 5; i++) begin
            host.rd(offs[i], q);
            chk("register byte", {18'h0, sh[i]}, {18'h0, q});
        end
        chk("field outputs", fexp(), got);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Hang guard, far beyond the fewer than a hundred cycles the tests need
    initial begin
        repeat (3000) @(posedge clk_sys);
        err_count++;
        results();
    end
    initial begin
        rst_sh();
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        chk_all();
        foreach (rows[i]) begin
            host.wr(rows[i].a, rows[i].d);
            if (slot(rows[i].a) < 5) sh[slot(rows[i].a)] = rows[i].d;
            host.rd(rows[i].a, q);
            chk("readback", {18'h0, rows[i].q}, {18'h0, q});
            chk("field outputs", fexp(), got);
        end
        // Read in the write's own edge still returns the old byte
        host.wr_peek(SCTC_OFF_CHAN3_TRACK, 8'h02, q, q2);
        chk("old byte", {18'h0, sh[4]}, {18'h0, q});
        chk("new byte", 26'h02, {18'h0, q2});
        // Second reset; a write presented while it is held must be lost
        @(posedge clk_sys);
        reset <= 1'b1;
        host.wr(SCTC_OFF_CHAN12_TRACK, 8'hff);
        reset <= 1'b0;
        rst_sh();
        chk_all();
        // Merged update of the channel 0 factor keeps reserved bits
        host.rmw(SCTC_OFF_CHAN0_TRACK, 8'h06, 8'h06);
        sh[1] = 8'hde;
        chk_all();
        results();
    end
endmodule // sensor_channel_tracking_config_bench
